// *** src/pdmc_host.sv ***
// Host end: bit clock generation and two-counter decimation.
// Behaviour
// - Bit clock stays between 1 and 3.3 MHz.
// - Select level held static during capture.
// - Select low: data read on rising edge.
// - Select high: data read on falling edge.
// - One is positive pulse, zero negative.
// - All ones maximum, all zeros minimum.
// - Two sources share wire on opposite edges.
// - Integrate input minus previous bit, compare half.
// - Ones density equals input fraction.
// - Sample equals ones counted over window.
// - Bit clock near typical 2.4 MHz.
// - Two interleaved counters over 128-bit windows.
`timescale 1ns/1ns
module pdmc_host #(
	parameter int HALF = pdmc_pkg::HALF_CYC,
	parameter int WIN = pdmc_pkg::WINDOW_BITS,
	parameter int DEPTH = pdmc_pkg::FIFO_DEPTH
) (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic ENABLE,
	input wire logic CHANNEL_SEL,
	pdmc_link_if.host LINK,
	output logic [pdmc_pkg::SAMPLE_W-1:0] SAMPLE_DATA,
	output logic SAMPLE_VALID,
	input wire logic SAMPLE_READY,
	output logic OVERRUN
);
	import pdmc_pkg::*;

	// Last bit position of each window.
	localparam logic [POS_W-1:0] END_A = POS_W'(WIN - 1);
	localparam logic [POS_W-1:0] END_B = POS_W'(WIN - 1 - WINDOW_OFFSET);
	localparam logic [DIV_W-1:0] DIV_END = DIV_W'(HALF - 1);

	// Sequencer state.
	pdmc_state_t state_r;
	// Captured select level, divider count and bit clock.
	logic sel_r;
	logic [DIV_W-1:0] div_r;
	logic bclk_r;
	// Data pin synchroniser.
	logic data_s1_r;
	logic data_s2_r;
	// Bit position and the two window counters.
	logic [POS_W-1:0] pos_r;
	logic [SAMPLE_W-1:0] cnt_a_r;
	logic [SAMPLE_W-1:0] cnt_b_r;
	// The second counter's first window is partial and is skipped.
	logic b_primed_r;
	// Result waiting for the FIFO.
	logic pend_r;
	logic [SAMPLE_W-1:0] pend_data_r;
	logic overrun_r;
	// Combinational events.
	logic running;
	logic half_end;
	logic tick;
	logic done_a;
	logic done_b;
	logic result_ok;
	logic [SAMPLE_W-1:0] result;
	logic fifo_ready;

	// Next count of a window counter; it restarts after its last bit.
	function automatic logic [SAMPLE_W-1:0] win_next(
		input logic [SAMPLE_W-1:0] cnt,
		input logic bit_in,
		input logic done
	);
		win_next = done ? '0 : cnt + SAMPLE_W'(bit_in);
	endfunction : win_next

	assign running = (state_r == PDMC_RUN);
	assign half_end = running & (div_r == DIV_END);
	// Sample half a period after the reading edge, at the end of the
	// following phase, so both synchroniser delays are covered while
	// the microphone still drives the wire.
	assign tick = half_end & (sel_r ? ~bclk_r : bclk_r);
	assign done_a = tick & (pos_r == END_A);
	assign done_b = tick & (pos_r == END_B) & b_primed_r;
	// The window's last bit is added into the result it finishes.
	assign result = done_a ? cnt_a_r + SAMPLE_W'(data_s2_r)
		: cnt_b_r + SAMPLE_W'(data_s2_r);
	assign result_ok = done_a | done_b;

	// Sequencer: idle holds the clock low, run toggles it.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= PDMC_IDLE;
		end else begin
			case (state_r)
				PDMC_IDLE: begin
					if (ENABLE) begin
						state_r <= PDMC_RUN;
					end
				end
				PDMC_RUN: begin
					if (!ENABLE) begin
						state_r <= PDMC_IDLE;
					end
				end
				default: begin
					state_r <= PDMC_IDLE;
				end
			endcase
		end
	end

	// Select is caught only while idle, so it never moves mid-run.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			sel_r <= SEL_RESET;
		end else if (!running) begin
			sel_r <= CHANNEL_SEL;
		end
	end

	// Divider: HALF cycles per phase gives 2.5 MHz at the default.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			div_r <= '0;
			bclk_r <= 1'b0;
		end else if (!running) begin
			div_r <= '0;
			bclk_r <= 1'b0;
		end else if (half_end) begin
			div_r <= '0;
			bclk_r <= ~bclk_r;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// Data pin passes two flops before it is counted.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			data_s1_r <= 1'b0;
			data_s2_r <= 1'b0;
		end else begin
			data_s1_r <= LINK.data;
			data_s2_r <= data_s1_r;
		end
	end

	// Bit position wraps every window; counter B is half a window late.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			pos_r <= '0;
			b_primed_r <= 1'b0;
		end else if (!running) begin
			pos_r <= '0;
			b_primed_r <= 1'b0;
		end else if (tick) begin
			pos_r <= pos_r + 1'b1;
			if (pos_r == END_B) begin
				b_primed_r <= 1'b1;
			end
		end
	end

	// Two interleaved ones counters, each over WIN bit periods.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_a_r <= '0;
			cnt_b_r <= '0;
		end else if (!running) begin
			cnt_a_r <= '0;
			cnt_b_r <= '0;
		end else if (tick) begin
			cnt_a_r <= win_next(cnt_a_r, data_s2_r, pos_r == END_A);
			cnt_b_r <= win_next(cnt_b_r, data_s2_r, pos_r == END_B);
		end
	end

	// Holding slot: a new result replaces an unsent one and flags it.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			pend_r <= 1'b0;
			pend_data_r <= '0;
		end else if (result_ok) begin
			pend_r <= 1'b1;
			pend_data_r <= result;
		end else if (pend_r & fifo_ready) begin
			pend_r <= 1'b0;
		end
	end

	// Overrun pulse: the FIFO stayed full for a whole half window.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			overrun_r <= 1'b0;
		end else begin
			overrun_r <= result_ok & pend_r & ~fifo_ready;
		end
	end

	// Sample FIFO toward the user side.
	pdmc_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(CLOCK),
		.rst_n(RSTN),
		.in_valid(pend_r),
		.in_ready(fifo_ready),
		.in_data(pend_data_r),
		.out_valid(SAMPLE_VALID),
		.out_ready(SAMPLE_READY),
		.out_data(SAMPLE_DATA)
	);

	assign LINK.bclk = bclk_r;
	assign LINK.channel_edge_select_pin = sel_r;
	assign OVERRUN = overrun_r;
endmodule : pdmc_host

// *** src/pdmc_pkg.sv ***
// Package of shared constants and types for the microphone capture link.
package pdmc_pkg;
	// System clock rate in kHz (50 ns period).
	localparam int CLK_KHZ = 20000;
	// Lowest, typical and highest bit clock rates in kHz.
	localparam int BCLK_MIN_KHZ = 1000;
	localparam int BCLK_TYP_KHZ = 2400;
	localparam int BCLK_MAX_KHZ = 3300;
	// Half bit period in system cycles; rounding down gives 2.5 MHz.
	localparam int HALF_CYC = CLK_KHZ / (2 * BCLK_TYP_KHZ);
	// Width of the half-period divider counter.
	localparam int DIV_W = 4;
	// Bit periods in one counting window (7-bit precision).
	localparam int WINDOW_BITS = 128;
	// Offset of the second counter's window against the first.
	localparam int WINDOW_OFFSET = 64;
	// Width of the bit position counter within a window.
	localparam int POS_W = 7;
	// Width of one recovered sample; it holds 0 to 128.
	localparam int SAMPLE_W = 8;
	// Width of the analog level word that feeds the modulator.
	localparam int LEVEL_W = 8;
	// Depth of the sample FIFO.
	localparam int FIFO_DEPTH = 8;
	// Reset value of the captured channel select.
	localparam logic SEL_RESET = 1'b0;

	// Host sequencer states, Gray coded.
	typedef enum logic [1:0] {
		PDMC_IDLE = 2'b00,
		PDMC_RUN = 2'b01
	} pdmc_state_t;
endpackage : pdmc_pkg

// *** src/pdmc_link_if.sv ***
// Interface carrying the bit clock, select level and data wire.
`timescale 1ns/1ns
interface pdmc_link_if;
	// Bit clock driven by the host.
	logic bclk;
	// Channel edge select level driven by the host.
	logic channel_edge_select_pin;
	// Microphone data drive and its enable.
	logic data_o;
	logic data_oe;
	// Resolved data wire; a released wire reads as its pull-down level.
	wire data;
	assign data = data_oe ? data_o : 1'b0;

	// Host end: makes the clock and select, reads the data wire.
	modport host (
		output bclk,
		output channel_edge_select_pin,
		input data
	);
	// Microphone end: reads clock and select, drives the data wire.
	modport mic (
		input bclk,
		input channel_edge_select_pin,
		output data_o,
		output data_oe
	);
endinterface : pdmc_link_if

// *** src/pdmc_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module pdmc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Storage words, addressed by the pointers.
	logic [WIDTH-1:0] mem_r [DEPTH];
	// Read and write pointers and the fill count.
	logic [AW-1:0] rd_r;
	logic [AW-1:0] wr_r;
	logic [AW:0] fill_r;
	// Handshakes that really move a word.
	logic push;
	logic pop;

	// Full and empty come straight from the fill count.
	assign in_ready = (fill_r != (AW+1)'(DEPTH));
	assign out_valid = (fill_r != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_r[rd_r];

	// Pointer wrap helper, used by both pointers.
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	// Write side: store the word and advance.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_r <= '0;
		end else if (push) begin
			mem_r[wr_r] <= in_data;
			wr_r <= bump(wr_r);
		end
	end

	// Read side advances on each pop.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_r <= '0;
		end else if (pop) begin
			rd_r <= bump(rd_r);
		end
	end

	// Fill count; a simultaneous push and pop leave it unchanged.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fill_r <= '0;
		end else if (push & ~pop) begin
			fill_r <= fill_r + 1'b1;
		end else if (pop & ~push) begin
			fill_r <= fill_r - 1'b1;
		end
	end
endmodule : pdmc_fifo

// *** src/pdmc_mic.sv ***
// Microphone end: delta-sigma modulator driving the shared data wire.
`timescale 1ns/1ns
module pdmc_mic (
	input wire logic CLOCK,
	input wire logic RSTN,
	pdmc_link_if.mic LINK,
	input wire logic [pdmc_pkg::LEVEL_W-1:0] MIC_LEVEL
);
	import pdmc_pkg::*;

	// Full scale and half scale in accumulator units.
	localparam int ACC_W = LEVEL_W + 3;
	localparam logic signed [ACC_W-1:0] FULL = ACC_W'(2 ** LEVEL_W);
	localparam logic signed [ACC_W-1:0] HALF = ACC_W'(2 ** (LEVEL_W - 1));

	// Synchronisers for the bit clock and select pins.
	logic bclk_s1_r;
	logic bclk_s2_r;
	logic bclk_d_r;
	logic sel_s1_r;
	logic sel_s2_r;
	// Last synchronised select level, to spot a change of edge.
	logic sel_d_r;
	// Integrator, output bit and drive enable.
	logic signed [ACC_W-1:0] acc_r;
	logic signed [ACC_W-1:0] acc_nxt;
	logic bit_r;
	logic oe_r;
	// Edge events of the synchronised bit clock.
	logic rise;
	logic fall;
	logic launch;
	logic release_bus;
	// Select moved while the clock was stopped.
	logic sel_flip;

	// Two flops on each pin before any logic looks at it.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			bclk_s1_r <= 1'b0;
			bclk_s2_r <= 1'b0;
			bclk_d_r <= 1'b0;
			sel_s1_r <= 1'b0;
			sel_s2_r <= 1'b0;
			sel_d_r <= 1'b0;
		end else begin
			bclk_s1_r <= LINK.bclk;
			bclk_s2_r <= bclk_s1_r;
			bclk_d_r <= bclk_s2_r;
			sel_s1_r <= LINK.channel_edge_select_pin;
			sel_s2_r <= sel_s1_r;
			sel_d_r <= sel_s2_r;
		end
	end

	assign rise = bclk_s2_r & ~bclk_d_r;
	assign fall = ~bclk_s2_r & bclk_d_r;
	// A new bit is launched half a period before the edge it is read on.
	assign launch = sel_s2_r ? rise : fall;
	// Drive stops at the reading edge, freeing the wire for the twin.
	assign release_bus = sel_s2_r ? fall : rise;
	// A clock stopped after a launch leaves the wire driven; a new
	// select level means the old half period is gone, so let go.
	assign sel_flip = sel_s2_r ^ sel_d_r;

	// Integrate input minus the previous output bit.
	always_comb begin
		acc_nxt = acc_r + ACC_W'(MIC_LEVEL) - (bit_r ? FULL : '0);
	end

	// Modulator state moves once per bit period.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			acc_r <= '0;
			bit_r <= 1'b0;
		end else if (launch) begin
			acc_r <= acc_nxt;
			// One marks a positive pulse, zero a negative one.
			bit_r <= (acc_nxt > HALF);
		end
	end

	// Drive enable covers only this channel's half of the period.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			oe_r <= 1'b0;
		end else if (launch) begin
			oe_r <= 1'b1;
		end else if (release_bus | sel_flip) begin
			oe_r <= 1'b0;
		end
	end

	assign LINK.data_o = bit_r;
	assign LINK.data_oe = oe_r;
endmodule : pdmc_mic

// *** testbench/pdmc_link_props.sv ***
// Concurrent checks on the link wires between host and microphone.
`timescale 1ns/1ns
module pdmc_link_props (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic bclk,
	input wire logic channel_edge_select_pin,
	input wire logic data_o,
	input wire logic data_oe,
	input wire logic data
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	// Edge on which the microphone puts out a new bit.
	sequence launch_edge;
		($fell(bclk) && !channel_edge_select_pin) ||
		($rose(bclk) && channel_edge_select_pin);
	endsequence
	// Edge on which the host is meant to read the bit.
	sequence read_edge;
		($rose(bclk) && !channel_edge_select_pin) ||
		($fell(bclk) && channel_edge_select_pin);
	endsequence
	// Two launches one bit period apart, so a whole bit lay between.
	sequence full_bit;
		launch_edge ##8 launch_edge;
	endsequence
	a_bclk_high_half: assert property ($rose(bclk) |-> bclk[*4] ##1 !bclk)
		else $error("bit clock high phase is not four cycles");
	a_bclk_low_half: assert property ($fell(bclk) |-> (!bclk)[*4])
		else $error("bit clock low phase is short");
	a_select_static: assert property (bclk |-> $stable(channel_edge_select_pin))
		else $error("select level moved while clocking");
	a_launch_after_edge: assert property (launch_edge |-> ##[3:5] data_oe)
		else $error("data not driven after launch edge");
	a_release_after_read: assert property (read_edge |-> ##[3:5] !data_oe)
		else $error("data wire not released after read edge");
	// The bit stands from just after the first launch until just
	// before the drive is released, two cycles before the next.
	a_bit_held_through: assert property (full_bit |->
		$past(data_oe, 5) && $past(data_oe, 2))
		else $error("bit not held across the read edge");
	a_bit_steady_drive: assert property (data_oe && $past(data_oe) |->
		$stable(data_o))
		else $error("data bit changed while driven");
	a_wire_follows_drive: assert property (data_oe |-> data == data_o)
		else $error("wire does not carry the driven bit");
endmodule : pdmc_link_props

// *** testbench/pdmc_microphone_capture_bench.sv ***
// Self-checking bench: host end against microphone end over one link.
`timescale 1ns/1ns
module pdmc_microphone_capture_bench;
	import pdmc_pkg::*;
	// Bit period in cycles and spacing of results (half a window).
	localparam int BITC = 8;
	localparam int GAP = 64 * BITC;
	localparam int LIMIT = 40000;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic enable = 1'b0;
	logic chan_sel = 1'b0;
	logic ready = 1'b0;
	logic [LEVEL_W-1:0] level = 8'h00;
	logic [SAMPLE_W-1:0] sample;
	logic valid;
	logic overrun;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	// Levels swept: floor, the 0.4 example, mid scale and top.
	logic [7:0] lv [4] = '{8'h00, 8'h66, 8'h80, 8'hFF};
	pdmc_link_if pdmc_link_if_i ();
	wire bclk = pdmc_link_if_i.bclk;
	pdmc_host #(.HALF(4), .WIN(128), .DEPTH(8)) pdmc_host_i (
		.CLOCK(clock), .RSTN(rstn), .ENABLE(enable),
		.CHANNEL_SEL(chan_sel), .LINK(pdmc_link_if_i.host),
		.SAMPLE_DATA(sample), .SAMPLE_VALID(valid),
		.SAMPLE_READY(ready), .OVERRUN(overrun));
	pdmc_mic pdmc_mic_i (.CLOCK(clock), .RSTN(rstn),
		.LINK(pdmc_link_if_i.mic), .MIC_LEVEL(level));
	pdmc_link_props pdmc_link_props_i (.CLOCK(clock), .RSTN(rstn),
		.bclk(pdmc_link_if_i.bclk), .data(pdmc_link_if_i.data),
		.channel_edge_select_pin(pdmc_link_if_i.channel_edge_select_pin),
		.data_o(pdmc_link_if_i.data_o), .data_oe(pdmc_link_if_i.data_oe));
	// Free-running system clock.
	always #25 clock = ~clock;
	// Cycle count, also the guard against a hung run.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			error_cnt++;
			test_done();
		end
	end
	// Counts one comparison and reports a difference.
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Waits on settled values for the bit clock to reach a level.
	task automatic wait_bclk(input logic v);
		do @(negedge clock); while (bclk !== v);
	endtask : wait_bclk
	// Takes the next result and the cycle at which it showed up; ready
	// is high, so it pops at the next edge.
	task automatic take(output logic [11:0] d, output int at);
		int n;
		n = 0;
		while (valid !== 1'b1 && n < 1500) begin
			@(negedge clock);
			n++;
		end
		at = cyc;
		check({11'h000, valid}, 12'h001);
		d = {4'h0, sample};
		@(negedge clock);
	endtask : take
	// Stops just after a falling edge so no clock phase is cut short.
	task automatic stop_link;
		wait_bclk(1'b1);
		wait_bclk(1'b0);
		@(posedge clock);
		enable <= 1'b0;
		repeat (20) @(negedge clock);
		check({11'h000, bclk}, 12'h000);
	endtask : stop_link
	// One capture at a fixed level and select; the first result is
	// skipped because it carries a bit from before the start.
	task automatic run_level(input logic sel, input logic [7:0] lvl);
		logic [11:0] d;
		logic [11:0] e;
		logic [11:0] tol;
		int t0;
		int t1;
		e = {5'h00, lvl[7:1]};
		tol = (lvl == 8'h00) ? 12'h000 : 12'h001;
		@(posedge clock);
		chan_sel <= sel;
		level <= lvl;
		ready <= 1'b1;
		repeat (2) @(posedge clock);
		enable <= 1'b1;
		wait_bclk(1'b1);
		t0 = cyc;
		wait_bclk(1'b0);
		wait_bclk(1'b1);
		check(12'(cyc - t0), 12'(BITC));
		take(d, t0);
		for (int k = 1; k < 4; k++) begin
			take(d, t1);
			check(12'(t1 - t0), 12'(GAP));
			t0 = t1;
			check({11'h000, d + tol >= e && d <= e + tol}, 12'h001);
		end
		stop_link();
		check({11'h000, valid}, 12'h000);
	endtask : run_level
	// Fills the FIFO with the reader stalled, then drains it.
	task automatic fill_drain;
		logic [11:0] n;
		int t0;
		@(posedge clock);
		chan_sel <= 1'b0;
		level <= 8'h66;
		ready <= 1'b0;
		repeat (2) @(posedge clock);
		enable <= 1'b1;
		t0 = cyc;
		while (overrun !== 1'b1) @(negedge clock);
		// Eight queued, one waiting, the tenth overwrites.
		check({11'h000, cyc - t0 > 5120 && cyc - t0 < 5800}, 12'h001);
		check({11'h000, valid}, 12'h001);
		stop_link();
		@(posedge clock);
		ready <= 1'b1;
		n = 12'h000;
		repeat (30) begin
			@(negedge clock);
			if (valid === 1'b1) n++;
		end
		check({11'h000, n == 12'h008 || n == 12'h009}, 12'h001);
		check({11'h000, valid}, 12'h000);
	endtask : fill_drain
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	// Main sequence: reset, both select levels at each level, overrun.
	initial begin
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		@(negedge clock);
		check({7'h00, bclk, pdmc_link_if_i.channel_edge_select_pin,
			pdmc_link_if_i.data_oe, valid, overrun}, 12'h000);
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 4; i++) begin
				run_level(s[0], lv[i]);
			end
		end
		fill_drain();
		test_done();
	end
endmodule : pdmc_microphone_capture_bench
